// file: hw/rxl_consts.svh
// Purpose: constants for the receive line status block
// Assumes: APB byte addresses, 32-bit data words
// Notes:   offsets are full byte addresses, fields are bit positions
`ifndef RXL_CONSTS_SVH
`define RXL_CONSTS_SVH

`define RXL_OFS_LINE_FLAGS  32'h5000_1114
`define RXL_OFS_SPARE       32'h5000_111C
`define RXL_OFS_SHADOW0     32'h5000_1130
`define RXL_OFS_LINE_CTRL   32'h5000_1140
`define RXL_OFS_FIFO_CTRL   32'h5000_1144
`define RXL_OFS_IRQ_STS     32'h5000_1148
`define RXL_OFS_IRQ_MASK    32'h5000_114C

`define RXL_BIT_DR          0
`define RXL_BIT_OE          1
`define RXL_BIT_PAR         2
`define RXL_BIT_FRM         3
`define RXL_BIT_BRK         4
`define RXL_BIT_PAR_EN      3
`define RXL_BIT_FIFO_EN     0

`define RXL_IRQ_DATA        0
`define RXL_IRQ_OVERRUN     1
`define RXL_IRQ_LINE        2

`define RXL_RST_SPARE       8'h00
`define RXL_RST_CTRL        8'h00
`define RXL_RST_IRQ         3'h0
`define RXL_FIFO_DEPTH      16

`endif

// file: hw/rxl_pkg.sv
// Purpose: types shared by the receive line status block
// Assumes: one received character per rx_char_valid pulse
// Notes:   entry layout is also the fifo word layout
package rxl_pkg;

  typedef struct packed {
    logic       brk;
    logic       frm_err;
    logic       par_err;
    logic [7:0] data;
  } rxl_char_t;

  typedef enum logic [1:0] {
    RXL_ST_IDLE = 2'b00,
    RXL_ST_WAIT = 2'b01,
    RXL_ST_DONE = 2'b11
  } rxl_state_t;

  typedef enum logic [2:0] {
    RXL_SEL_NONE,
    RXL_SEL_FLAGS,
    RXL_SEL_SPARE,
    RXL_SEL_SHADOW,
    RXL_SEL_LCTRL,
    RXL_SEL_FCTRL,
    RXL_SEL_ISTS,
    RXL_SEL_IMASK
  } rxl_sel_t;

endpackage

// file: hw/rxl_fifo_mem.sv
// Purpose: storage for the receive fifo
// Assumes: one write port, one read port, same clock
// Notes:   read data is registered, so it lags the address by one edge
`timescale 1ns/10ps
module rxl_fifo_mem
  import rxl_pkg::*;
#(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16,
  parameter int AW    = 4
)
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // write side
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read side
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= mem[raddr];
    end
  end

endmodule

// file: hw/rxl_status.sv
// Purpose: receive line status flags, receive buffering and spare byte, APB slave
// Assumes: receiver delivers checked characters as one-cycle pulses
// Notes:   reads that pop or clear act on the completing APB edge
//
// What this block does
// - parity fault flagged only with parity enabled, or on break
// - fifo mode reveals parity fault at head
// - break also sets parity fault with break
// - status read clears framing fault flag
// - status read clears parity fault flag
// - no fifo: new char overwrites, flags overrun
// - full fifo: flag overrun, drop new char
// - status read clears overrun flag
// - data available while any char waits
// - cleared by holding read or fifo empty
// - 8-bit scratch byte, resets zero, no effect
// - fifo mode only while fifo enable set
`timescale 1ns/10ps
`include "rxl_consts.svh"
module rxl_status
  import rxl_pkg::*;
#(
  parameter int DEPTH = `RXL_FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // from the receive shift register
  input  wire logic        rx_char_valid,
  input  wire rxl_char_t   rx_char,
  // status outputs
  output logic             rx_data_available,
  output logic             irq
);

  function automatic rxl_sel_t reg_sel(input logic [31:0] a);
    case (a)
      `RXL_OFS_LINE_FLAGS: reg_sel = RXL_SEL_FLAGS;
      `RXL_OFS_SPARE:      reg_sel = RXL_SEL_SPARE;
      `RXL_OFS_SHADOW0:    reg_sel = RXL_SEL_SHADOW;
      `RXL_OFS_LINE_CTRL:  reg_sel = RXL_SEL_LCTRL;
      `RXL_OFS_FIFO_CTRL:  reg_sel = RXL_SEL_FCTRL;
      `RXL_OFS_IRQ_STS:    reg_sel = RXL_SEL_ISTS;
      `RXL_OFS_IRQ_MASK:   reg_sel = RXL_SEL_IMASK;
      default:             reg_sel = RXL_SEL_NONE;
    endcase
  endfunction

  rxl_state_t    state_q;
  rxl_sel_t      sel;
  logic [7:0]    spare_q, lctrl_q, fctrl_q;
  logic [2:0]    ists_q, imask_q;
  logic          par_err_q, frm_err_q, brk_q, oe_q;
  rxl_char_t     hold_q;
  logic          hold_valid_q;
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [AW:0]   count_q;
  logic          revealed_q, head_stale_q;
  rxl_char_t     head, rx_eff;
  logic          fifo_mode, par_en, fifo_full;
  logic          done, rd_done, wr_done, flags_rd_done, hold_rd_done;
  logic          push, pop, flush, reveal, overrun_evt;
  logic          set_par, set_frm, set_brk, dr_c;
  logic [31:0]   rdata_c;

  assign sel       = reg_sel(paddr);
  assign fifo_mode = fctrl_q[`RXL_BIT_FIFO_EN];
  assign par_en    = lctrl_q[`RXL_BIT_PAR_EN];
  assign done      = (state_q == RXL_ST_DONE) && psel && penable;
  assign rd_done   = done && !pwrite;
  assign wr_done   = done && pwrite;
  assign flags_rd_done = rd_done && (sel == RXL_SEL_FLAGS);
  assign hold_rd_done  = rd_done && (sel == RXL_SEL_SHADOW);
  assign fifo_full = (count_q == (AW+1)'(DEPTH));

  // break forces parity and framing faults; parity fault needs parity enabled
  always_comb
  begin
    rx_eff      = rx_char;
    rx_eff.par_err = (rx_char.par_err && par_en) || rx_char.brk;
    rx_eff.frm_err = rx_char.frm_err || rx_char.brk;
  end

  // leaving or entering fifo mode drops whatever was buffered
  assign flush = wr_done && (sel == RXL_SEL_FCTRL)
                 && (pwdata[`RXL_BIT_FIFO_EN] != fifo_mode);
  assign pop   = fifo_mode && hold_rd_done && (count_q != '0);
  assign push  = fifo_mode && rx_char_valid && (!fifo_full || pop) && !flush;
  assign overrun_evt = rx_char_valid && (fifo_mode ? (fifo_full && !pop)
                                                   : (hold_valid_q && !hold_rd_done));
  // head errors only show once the registered read data has settled
  assign reveal = fifo_mode && (count_q != '0) && !revealed_q && !head_stale_q;
  assign set_par = fifo_mode ? reveal && head.par_err : rx_char_valid && rx_eff.par_err;
  assign set_frm = fifo_mode ? reveal && head.frm_err : rx_char_valid && rx_eff.frm_err;
  assign set_brk = fifo_mode ? reveal && head.brk : rx_char_valid && rx_eff.brk;
  assign dr_c   = fifo_mode ? (count_q != '0) : hold_valid_q;

  rxl_fifo_mem #(
    .WIDTH ($bits(rxl_char_t)),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (push),
    .waddr   (wr_ptr_q),
    .wdata   (rx_eff),
    .raddr   (rd_ptr_q),
    .rdata_q (head)
  );

  always_comb
  begin
    rdata_c = '0;
    case (sel)
      RXL_SEL_FLAGS:
      begin
        rdata_c[`RXL_BIT_DR] = dr_c;
        rdata_c[`RXL_BIT_OE] = oe_q;
        rdata_c[`RXL_BIT_PAR] = par_err_q;
        rdata_c[`RXL_BIT_FRM] = frm_err_q;
        rdata_c[`RXL_BIT_BRK] = brk_q;
      end
      RXL_SEL_SPARE:  rdata_c[7:0] = spare_q;
      RXL_SEL_SHADOW: rdata_c[7:0] = fifo_mode ? head.data : hold_q.data;
      RXL_SEL_LCTRL:  rdata_c[7:0] = lctrl_q;
      RXL_SEL_FCTRL:  rdata_c[7:0] = fctrl_q;
      RXL_SEL_ISTS:   rdata_c[2:0] = ists_q;
      RXL_SEL_IMASK:  rdata_c[2:0] = imask_q;
      default:        rdata_c = '0;
    endcase
  end

  // apb handshake; read data is latched on the same edge that raises pready so it is stable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= RXL_ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      unique case (state_q)
        RXL_ST_IDLE:
        begin
          if (psel && !penable)
          begin
            state_q <= RXL_ST_WAIT;
          end
        end
        RXL_ST_WAIT:
        begin
          if (!head_stale_q)
          begin
            state_q <= RXL_ST_DONE;
            pready  <= 1'b1;
            pslverr <= (sel == RXL_SEL_NONE);
            prdata  <= pwrite ? 32'h0000_0000 : rdata_c;
          end
        end
        RXL_ST_DONE:
        begin
          if (done)
          begin
            state_q <= RXL_ST_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
          end
        end
      endcase
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spare_q <= `RXL_RST_SPARE;
      lctrl_q <= `RXL_RST_CTRL;
      fctrl_q <= `RXL_RST_CTRL;
      imask_q <= `RXL_RST_IRQ;
    end
    else if (wr_done)
    begin
      case (sel)
        RXL_SEL_SPARE: spare_q <= pwdata[7:0];
        RXL_SEL_LCTRL: lctrl_q <= pwdata[7:0];
        RXL_SEL_FCTRL: fctrl_q <= pwdata[7:0];
        RXL_SEL_IMASK: imask_q <= pwdata[2:0];
        default:       ;
      endcase
    end
  end

  // single holding register for non-fifo operation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_q       <= '0;
      hold_valid_q <= 1'b0;
    end
    else
    begin
      if (!fifo_mode && rx_char_valid)
      begin
        hold_q       <= rx_eff;
        hold_valid_q <= 1'b1;
      end
      else if (hold_rd_done || flush)
      begin
        hold_valid_q <= 1'b0;
      end
    end
  end

  // fifo pointers and head tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_q     <= '0;
      rd_ptr_q     <= '0;
      count_q      <= '0;
      revealed_q   <= 1'b0;
      head_stale_q <= 1'b0;
    end
    else if (flush)
    begin
      wr_ptr_q     <= '0;
      rd_ptr_q     <= '0;
      count_q      <= '0;
      revealed_q   <= 1'b0;
      head_stale_q <= 1'b1;
    end
    else
    begin
      wr_ptr_q     <= wr_ptr_q + AW'(push);
      rd_ptr_q     <= rd_ptr_q + AW'(pop);
      count_q      <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      head_stale_q <= pop || (push && (count_q == '0));
      if (pop)
      begin
        revealed_q <= 1'b0;
      end
      else if (reveal)
      begin
        revealed_q <= 1'b1;
      end
    end
  end

  // line flags: a new event wins over a clear by status read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      par_err_q <= 1'b0;
      frm_err_q <= 1'b0;
      brk_q     <= 1'b0;
      oe_q      <= 1'b0;
    end
    else
    begin
      par_err_q <= set_par || (par_err_q && !(flags_rd_done && prdata[`RXL_BIT_PAR]));
      frm_err_q <= set_frm || (frm_err_q && !(flags_rd_done && prdata[`RXL_BIT_FRM]));
      brk_q     <= set_brk || (brk_q && !(flags_rd_done && prdata[`RXL_BIT_BRK]));
      oe_q      <= overrun_evt || (oe_q && !(flags_rd_done && prdata[`RXL_BIT_OE]));
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ists_q <= `RXL_RST_IRQ;
    end
    else
    begin
      ists_q <= {set_par || set_frm || set_brk, overrun_evt, push || (!fifo_mode && rx_char_valid)}
                | (ists_q & ~((wr_done && sel == RXL_SEL_ISTS) ? pwdata[2:0] : 3'h0));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq               <= 1'b0;
      rx_data_available <= 1'b0;
    end
    else
    begin
      irq               <= |(ists_q & imask_q);
      rx_data_available <= dr_c;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_nofifo_char;
    !fifo_mode && rx_char_valid;
  endsequence

  sequence s_flags_read;
    flags_rd_done ##0 !rx_char_valid && !reveal;
  endsequence

  a_parity_gated: assert property (
    s_nofifo_char ##0 (!rx_char.par_err || !par_en) && !rx_char.brk && !par_err_q |=> !par_err_q)
    else $error("parity fault set with parity disabled");
  a_fifo_par_held: assert property (
    fifo_mode && !reveal && !par_err_q |=> !par_err_q)
    else $error("parity fault shown before char reached head");
  a_break_par: assert property (
    s_nofifo_char ##0 rx_char.brk |=> par_err_q && brk_q && frm_err_q)
    else $error("break did not raise parity fault");
  a_read_clr_frm: assert property (
    s_flags_read ##0 prdata[`RXL_BIT_FRM] |=> !frm_err_q)
    else $error("framing fault not cleared by status read");
  a_read_clr_par: assert property (
    s_flags_read ##0 prdata[`RXL_BIT_PAR] |=> !par_err_q)
    else $error("parity fault not cleared by status read");
  a_hold_overrun: assert property (
    s_nofifo_char ##0 hold_valid_q && !hold_rd_done
      |=> oe_q && hold_q.data == $past(rx_char.data))
    else $error("overrun not flagged or holding not overwritten");
  a_fifo_overrun: assert property (
    fifo_mode && rx_char_valid && fifo_full && !pop && !flush
      |=> oe_q && count_q == $past(count_q) && wr_ptr_q == $past(wr_ptr_q))
    else $error("full fifo overrun handled wrongly");
  a_read_clr_oe: assert property (
    s_flags_read ##0 prdata[`RXL_BIT_OE] && !overrun_evt |=> !oe_q)
    else $error("overrun not cleared by status read");
  a_data_shown: assert property (
    !fifo_mode && hold_valid_q && !hold_rd_done && !flush |=> ##1 rx_data_available)
    else $error("data available low while holding full");
  a_data_clears: assert property (
    !fifo_mode && hold_rd_done && !rx_char_valid ##1 !rx_char_valid |=> !rx_data_available)
    else $error("data available not cleared by holding read");
  a_spare_store: assert property (
    wr_done && sel == RXL_SEL_SPARE |=> spare_q == $past(pwdata[7:0]))
    else $error("spare byte not stored");
  a_fifo_idle: assert property (
    !fifo_mode |-> count_q == '0)
    else $error("fifo holds data outside fifo mode");

endmodule

// file: verification/rxl_tx_model.sv
// Purpose: remote serial transmitter seen as finished characters
// Assumes: one character per one-cycle valid pulse, no back pressure
// Notes:   between characters the data lines show the inverse of the
//          last character, so stale data can never look valid
`timescale 1ns/10ps
module rxl_tx_model
  import rxl_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // character stream toward the receiver
  output logic            rx_char_valid,
  output rxl_char_t       rx_char
);
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char       = '0;
  end

  task automatic send(input rxl_char_t c);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char       <= c;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char       <= ~c;
  endtask
endmodule

// file: verification/rxl_status_bench.sv
// Purpose: self-checking bench for the receive line status block
// Assumes: apb master with bounded waits, fifo depth cut to 4
// Notes:   expected flag words are built from the bit positions
`timescale 1ns/10ps
`include "rxl_consts.svh"
module rxl_status_bench
  import rxl_pkg::*;
;
  localparam int          DEPTH = 4;
  localparam logic [31:0] DR    = 32'h1 << `RXL_BIT_DR;
  localparam logic [31:0] OE    = 32'h1 << `RXL_BIT_OE;
  localparam logic [31:0] PAR   = 32'h1 << `RXL_BIT_PAR;
  localparam logic [31:0] FRM   = 32'h1 << `RXL_BIT_FRM;
  localparam logic [31:0] BRK   = 32'h1 << `RXL_BIT_BRK;
  localparam logic [31:0] FLG   = `RXL_OFS_LINE_FLAGS;
  localparam logic [31:0] SHD   = `RXL_OFS_SHADOW0;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_char_valid;
  rxl_char_t   rx_char;
  logic        rx_data_available;
  logic        irq;
  int          failures;
  int          comparisons;
  logic [31:0] rdat;
  logic        rerr;

  rxl_status #(.DEPTH(DEPTH)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_data_available(rx_data_available), .irq(irq)
  );

  rxl_tx_model u_tx (.pclk(pclk), .rx_char_valid(rx_char_valid), .rx_char(rx_char));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic complete_run;
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // the request stays put until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      complete_run();
    end
    else
    begin
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdat, rerr);
    check(rdat, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial
  begin
    failures    = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RXL_OFS_SPARE, 32'h0);
    rd(FLG, 32'h0);
    wr(`RXL_OFS_SPARE, 32'hFFFF_FFFF);
    rd(`RXL_OFS_SPARE, 32'hFF);
    apb(1'b0, 32'h5000_1100, 32'h0, rdat, rerr);
    check({31'h0, rerr}, 32'h1);
    check(rdat, 32'h0);
    // parity check off: a bad character sets no parity fault
    u_tx.send(rxl_char_t'{1'b0, 1'b0, 1'b1, 8'h3C});
    idle(3);
    check({31'h0, rx_data_available}, 32'h1);
    rd(FLG, DR);
    rd(SHD, 32'h3C);
    idle(3);
    check({31'h0, rx_data_available}, 32'h0);
    u_tx.send(rxl_char_t'{1'b1, 1'b0, 1'b0, 8'h00});
    idle(3);
    rd(FLG, DR | PAR | FRM | BRK);
    rd(SHD, 32'h0);
    wr(`RXL_OFS_LINE_CTRL, 32'h1 << `RXL_BIT_PAR_EN);
    u_tx.send(rxl_char_t'{1'b0, 1'b1, 1'b1, 8'h5A});
    idle(3);
    rd(FLG, DR | PAR | FRM);
    rd(FLG, DR);
    u_tx.send(rxl_char_t'{1'b0, 1'b0, 1'b0, 8'hC3});
    idle(3);
    rd(FLG, DR | OE);
    rd(SHD, 32'hC3);
    idle(3);
    rd(FLG, 32'h0);
    // fifo mode: errors show only when their character is at the head
    wr(`RXL_OFS_FIFO_CTRL, 32'h1 << `RXL_BIT_FIFO_EN);
    u_tx.send(rxl_char_t'{1'b0, 1'b0, 1'b0, 8'h11});
    u_tx.send(rxl_char_t'{1'b0, 1'b0, 1'b1, 8'h22});
    idle(4);
    rd(FLG, DR);
    rd(SHD, 32'h11);
    idle(4);
    rd(FLG, DR | PAR);
    rd(SHD, 32'h22);
    idle(4);
    rd(FLG, 32'h0);
    for (int i = 0; i <= DEPTH; i++)
      u_tx.send(rxl_char_t'{1'b0, 1'b0, 1'b0, 8'h40 + 8'(i)});
    idle(4);
    rd(FLG, DR | OE);
    for (int i = 0; i < DEPTH; i++)
    begin
      rd(SHD, 32'h40 + 32'(i));
      idle(3);
    end
    rd(FLG, 32'h0);
    idle(3);
    check({31'h0, rx_data_available}, 32'h0);
    // interrupt: clear, unmask arrivals, raise, clear again
    wr(`RXL_OFS_IRQ_STS, 32'h7);
    wr(`RXL_OFS_IRQ_MASK, 32'h1 << `RXL_IRQ_DATA);
    idle(3);
    check({31'h0, irq}, 32'h0);
    u_tx.send(rxl_char_t'{1'b0, 1'b0, 1'b0, 8'h77});
    idle(4);
    check({31'h0, irq}, 32'h1);
    rd(`RXL_OFS_IRQ_STS, 32'h1 << `RXL_IRQ_DATA);
    wr(`RXL_OFS_IRQ_STS, 32'h1 << `RXL_IRQ_DATA);
    idle(3);
    check({31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule
